// *** dv/serial_link_subclass_pattern_config_test.sv ***
// self-checking bench of the link config block
`timescale 1ns/1ps
`include "slsp_consts.svh"

module serial_link_subclass_pattern_config_test;
    logic clk, nrst, cs_n, sck, sdi, sdo, sdo_oe, frame_tick, sysref, sync_n;
    logic comma_burst, lmfc_wrap;
    logic [4:0] frames_per_mf_m1;
    logic [7:0] adc_octet, last_adc, prev, cur;
    logic [1:0] lane_drive_current;
    logic oe_seen;
    logic [8:0] seen, e;
    logic [14:0] s;
    slsp_pkg::slsp_char_t lane_char;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [8:0] exp_q[$];
    string name_q[$];
    event got;
    // {subclass register, source 1 = reference pulse, burst expected}
    logic [9:0] tbl [8] = '{10'h000, 10'h029, 10'h008, 10'h027,
                            10'h066, 10'h066, 10'h0e7, 10'h0e7};

    slsp_top i_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .frame_tick(frame_tick),
        .frames_per_mf_m1(frames_per_mf_m1), .sysref(sysref), .sync_n(sync_n),
        .adc_octet(adc_octet), .lane_char(lane_char), .comma_burst(comma_burst),
        .lmfc_wrap(lmfc_wrap), .lane_drive_current(lane_drive_current));
    slsp_rx_model i_rx (.clk(clk), .sysref(sysref), .sync_n(sync_n));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string nm, input logic [8:0] sv, input logic [8:0] ev);
        cmp_count++;
        if (sv !== ev)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, ev, sv);
        end
    endtask : check

    initial
    begin
        forever
        begin
            @(got);
            check(name_q.pop_front(), seen, exp_q.pop_front());
        end
    end

    // note the expectation, then hand the observed value to the watcher
    task automatic result(input string nm, input logic [8:0] ev, input logic [8:0] sv);
        name_q.push_back(nm);
        exp_q.push_back(ev);
        seen = sv;
        ->got;
        #1;
    endtask : result

    task automatic wrap_up;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // sck levels held 4 clocks so the sampled edges settle before sdo is read
    task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sdi <= w[i];
            repeat (4) @(posedge clk);
            if (i < 8)
                q = {q[6:0], sdo};
            if (i == 0)
                oe_seen = sdo_oe;
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : spi

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
        result("sdo_oe", 9'h000, {8'h00, oe_seen});
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] ev);
        logic [7:0] q;
        spi(1'b1, a, 8'h00, q);
        result("reg", {1'b0, ev}, {1'b0, q});
        result("sdo_oe", 9'h001, {8'h00, oe_seen});
    endtask : rd

    task automatic frame;
        logic [7:0] v;
        v = 8'($urandom_range(0, 255));
        @(posedge clk);
        frame_tick <= 1'b1;
        adc_octet <= v;
        @(posedge clk);
        frame_tick <= 1'b0;
        #1;
        last_adc = v;
    endtask : frame

    task automatic align(input logic src, input logic b);
        // at least one frame, so each pulse lands in the last frame of a multiframe
        frame();
        for (int n = 0; n < 40 && lmfc_wrap !== 1'b1; n++)
            frame();
        i_rx.pulse(src);
        if (!b)
            result("burst", 9'h000, {8'h00, comma_burst});
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                result("burst", 9'h001, {8'h00, comma_burst});
                result("wrap", {8'h00, i == 3}, {8'h00, lmfc_wrap});
                frame();
                result("comma", {1'b1, `SLSP_K28_5}, lane_char);
            end
            result("burst", 9'h000, {8'h00, comma_burst});
        end
    endtask : align

    initial
    begin
        #2_000_000;
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(29));
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        frame_tick = 1'b0;
        adc_octet = 8'h00;
        frames_per_mf_m1 = 5'h03;
        nrst = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(7'h08, 8'h00);
        rd(7'h09, 8'h00);
        rd(7'h0a, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr(7'h0a, {6'($urandom_range(0, 63)), c[1:0]});
            rd(7'h0a, {6'h00, c[1:0]});
            result("drive", {7'h00, c[1:0]}, {7'h00, lane_drive_current});
        end
        wr(7'h09, 8'hff);
        rd(7'h09, 8'h07);
        wr(7'h0b, 8'hff);
        rd(7'h0b, 8'h00);
        wr(7'h08, 8'hff);
        rd(7'h08, 8'hff);
        for (int p = 0; p < 4; p++)
        begin
            wr(7'h09, p[7:0]);
            frame();
            frame();
            e = p == 0 ? {1'b0, last_adc} : p == 1 ? {1'b1, `SLSP_K28_5} :
                p == 2 ? {1'b1, `SLSP_K28_7} : {1'b0, `SLSP_D21_5};
            result("pattern", e, lane_char);
        end
        wr(7'h09, 8'h04);
        frame();
        frame();
        prev = lane_char.octet;
        for (int k = 0; k < 3; k++)
        begin
            frame();
            cur = lane_char.octet;
            s = {prev[6:0], cur};
            repeat (8) s = {s[13:0], s[14] ^ s[13]};
            frame();
            result("prbs", {1'b0, s[7:0]}, lane_char);
            prev = lane_char.octet;
        end
        wr(7'h09, 8'h05);
        for (int n = 0; n < 40 && lmfc_wrap !== 1'b1; n++)
            frame();
        frame();
        result("align", {1'b1, `SLSP_K28_3}, lane_char);
        frame();
        result("align", {1'b1, `SLSP_K28_0}, lane_char);
        frame();
        result("align", 9'h001, lane_char);
        wr(7'h09, 8'h06);
        frame();
        prev = lane_char.octet;
        frame();
        result("ramp", {1'b0, prev + 8'h01}, lane_char);
        wr(7'h09, 8'h07);
        frame();
        prev = lane_char.octet;
        repeat (12) frame();
        result("rpat", {1'b0, prev}, lane_char);
        wr(7'h09, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            if (i == 0 || tbl[i][9:2] != tbl[i - 1][9:2])
                wr(7'h08, tbl[i][9:2]);
            align(tbl[i][1], tbl[i][0]);
        end
        wrap_up();
    end
endmodule : serial_link_subclass_pattern_config_test

// *** dv/slsp_rx_model.sv ***
// far-side receiver model: reference pulse and sync request
`timescale 1ns/1ps

module slsp_rx_model (
    input wire logic clk, // device clock
    output logic sysref, // reference pulse
    output logic sync_n // sync request, active low
);
    initial
    begin
        sysref = 1'b0;
        sync_n = 1'b1;
    end

    // pulse length varies, so short and long pulses reach the edge detector
    task automatic pulse(input logic src);
        int len;
        len = 2 + $urandom_range(0, 3);
        @(posedge clk);
        if (src)
            sysref <= 1'b1;
        else
            sync_n <= 1'b0;
        repeat (len) @(posedge clk);
        sysref <= 1'b0;
        sync_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pulse
endmodule : slsp_rx_model

// *** shared/slsp_consts.svh ***
// register map, field positions, reset values and line characters of the link config block
`ifndef SLSP_CONSTS_SVH
`define SLSP_CONSTS_SVH

`define SLSP_ADDR_SUBCLASS 7'h08
`define SLSP_ADDR_PATTERN 7'h09
`define SLSP_ADDR_DRIVE 7'h0a

`define SLSP_DEARM_HI 7
`define SLSP_DEARM_LO 5
`define SLSP_ALERT_BIT 4
`define SLSP_TXSYNC_BIT 3
`define SLSP_SUBCL_HI 2
`define SLSP_PAT_HI 2
`define SLSP_DRV_HI 1

`define SLSP_RST_SUBCLASS 8'h00
`define SLSP_RST_PATTERN 3'h0
`define SLSP_RST_DRIVE 2'h0

`define SLSP_SUBCL_0 3'h0
`define SLSP_SUBCL_1 3'h1
`define SLSP_SUBCL_2 3'h2

`define SLSP_K28_5 8'hbc
`define SLSP_K28_7 8'hfc
`define SLSP_D21_5 8'hb5
`define SLSP_K28_0 8'h1c
`define SLSP_K28_3 8'h7c

`define SLSP_PRBS_SEED 15'h7fff
`define SLSP_SPI_LAST 5'h0f
`define SLSP_SPI_ADDR_END 5'h07
`define SLSP_SPI_DATA_START 5'h08
`define SLSP_RPAT_LAST 4'hb

`endif

// *** shared/slsp_pkg.sv ***
// types shared by the link config block
package slsp_pkg;
    typedef enum logic [2:0] {
        SLSP_PAT_NORMAL = 3'b000,
        SLSP_PAT_K285 = 3'b001,
        SLSP_PAT_K287 = 3'b010,
        SLSP_PAT_D215 = 3'b011,
        SLSP_PAT_PRBS15 = 3'b100,
        SLSP_PAT_LANE_ALIGN = 3'b101,
        SLSP_PAT_TEST_SAMPLES = 3'b110,
        SLSP_PAT_RPAT = 3'b111
    } slsp_pat_t;

    typedef struct packed {
        logic is_k;
        logic [7:0] octet;
    } slsp_char_t;

    typedef struct packed {
        logic [2:0] dearm_len;
        logic alert;
        logic tx_sync;
        logic [2:0] subclass;
    } slsp_subclass_t;
endpackage : slsp_pkg

// *** src/slsp_spi_port.sv ***
// serial configuration port: 16-bit frames, read flag, 7-bit address, 8-bit data
`timescale 1ns/1ps
`include "slsp_consts.svh"

module slsp_spi_port (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic cs_n, // chip select, active low
    input wire logic sck, // serial clock, sampled
    input wire logic sdi, // serial data in
    input wire logic [7:0] rd_data, // read value for acc_addr
    output logic sdo, // serial data out
    output logic sdo_oe, // high while sdo is driven
    output logic wr_stb, // one-cycle write strobe
    output logic [6:0] acc_addr, // address of current frame
    output logic [7:0] wr_data // write data
);
    logic sck_d_ff;
    logic [4:0] cnt_ff;
    logic [7:0] shift_ff;
    logic rd_ff;
    logic [6:0] addr_ff;
    logic [7:0] wdat_ff;
    logic wstb_ff;
    logic [7:0] rsh_ff;
    wire sck_rise = ~cs_n & sck & ~sck_d_ff;
    wire sck_fall = ~cs_n & ~sck & sck_d_ff;
    wire [7:0] nxt_shift = {shift_ff[6:0], sdi};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_d_ff <= 1'b0;
            cnt_ff <= 5'h00;
            shift_ff <= 8'h00;
            rd_ff <= 1'b0;
            addr_ff <= 7'h00;
            wdat_ff <= 8'h00;
            wstb_ff <= 1'b0;
            rsh_ff <= 8'h00;
        end
        else
        begin
            sck_d_ff <= sck;
            wstb_ff <= 1'b0;
            if (cs_n)
                cnt_ff <= 5'h00;
            else if (sck_rise && cnt_ff <= `SLSP_SPI_LAST)
            begin
                shift_ff <= nxt_shift;
                cnt_ff <= cnt_ff + 5'h01;
                if (cnt_ff == 5'h00)
                    rd_ff <= sdi;
                if (cnt_ff == `SLSP_SPI_ADDR_END)
                    addr_ff <= nxt_shift[6:0];
                if (cnt_ff == `SLSP_SPI_LAST)
                begin
                    wdat_ff <= nxt_shift;
                    wstb_ff <= ~rd_ff;
                end
            end
            // read data is loaded once the address is known, then shifted on falls
            if (sck_fall && cnt_ff == `SLSP_SPI_DATA_START)
                rsh_ff <= rd_data;
            else if (sck_fall && cnt_ff > `SLSP_SPI_DATA_START)
                rsh_ff <= {rsh_ff[6:0], 1'b0};
        end
    end

    assign sdo = rsh_ff[7];
    assign sdo_oe = ~cs_n & rd_ff & (cnt_ff >= `SLSP_SPI_DATA_START);
    assign wr_stb = wstb_ff;
    assign acc_addr = addr_ff;
    assign wr_data = wdat_ff;
endmodule : slsp_spi_port

// *** src/slsp_top.sv ***
// link subclass, test pattern and drive configuration registers with their lane logic
`timescale 1ns/1ps
`include "slsp_consts.svh"

module slsp_top (
    input wire logic clk, // 25 MHz device clock
    input wire logic nrst, // async reset, active low
    input wire logic cs_n, // config port select, active low
    input wire logic sck, // config port clock
    input wire logic sdi, // config port data in
    output logic sdo, // config port data out
    output logic sdo_oe, // high while sdo driven
    input wire logic frame_tick, // one-cycle pulse per frame
    input wire logic [4:0] frames_per_mf_m1, // K minus one
    input wire logic sysref, // reference pulse level
    input wire logic sync_n, // receiver sync, active low
    input wire logic [7:0] adc_octet, // converter data octet
    output slsp_pkg::slsp_char_t lane_char, // character to the encoder
    output logic comma_burst, // resync burst in progress
    output logic lmfc_wrap, // last frame of multiframe
    output logic [1:0] lane_drive_current // CML current code
);
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    logic wr_stb;
    logic [6:0] acc_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    slsp_spi_port u_spi (
        .clk(clk),
        .rst_n(rst_n_ff),
        .cs_n(cs_n),
        .sck(sck),
        .sdi(sdi),
        .rd_data(rd_data),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .wr_stb(wr_stb),
        .acc_addr(acc_addr),
        .wr_data(wr_data)
    );

    slsp_pkg::slsp_subclass_t subcl_ff;
    logic [2:0] pat_ff;
    logic [1:0] drv_ff;
    wire wr_subcl = wr_stb & (acc_addr == `SLSP_ADDR_SUBCLASS);
    wire wr_pat = wr_stb & (acc_addr == `SLSP_ADDR_PATTERN);
    wire wr_drv = wr_stb & (acc_addr == `SLSP_ADDR_DRIVE);

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            subcl_ff <= `SLSP_RST_SUBCLASS;
            pat_ff <= `SLSP_RST_PATTERN;
            drv_ff <= `SLSP_RST_DRIVE;
        end
        else
        begin
            if (wr_subcl)
                subcl_ff <= wr_data;
            if (wr_pat)
                pat_ff <= wr_data[`SLSP_PAT_HI:0];
            if (wr_drv)
                drv_ff <= wr_data[`SLSP_DRV_HI:0];
        end
    end

    // unmapped addresses read zero
    assign rd_data = (acc_addr == `SLSP_ADDR_SUBCLASS) ? subcl_ff :
                     (acc_addr == `SLSP_ADDR_PATTERN) ? {5'h00, pat_ff} :
                     (acc_addr == `SLSP_ADDR_DRIVE) ? {6'h00, drv_ff} : 8'h00;
    assign lane_drive_current = drv_ff;

    logic sysref_d_ff;
    logic sync_d_ff;
    logic [4:0] lmfc_ff;
    logic armed_ff;
    logic [2:0] idle_mf_ff;
    logic [5:0] comma_ff;
    logic [1:0] mf_idx_ff;
    logic [7:0] ramp_ff;
    logic [3:0] rpat_idx_ff;
    logic [14:0] prbs_ff;
    slsp_pkg::slsp_char_t lane_ff;

    wire sysref_rise = sysref & ~sysref_d_ff;
    wire sync_rise = sync_n & ~sync_d_ff;
    wire sc1 = subcl_ff.subclass == `SLSP_SUBCL_1;
    wire sc2 = subcl_ff.subclass == `SLSP_SUBCL_2;
    wire mf_end = frame_tick & (lmfc_ff == frames_per_mf_m1);
    wire align_evt = (sc1 & sysref_rise & (~subcl_ff.alert | armed_ff)) | (sc2 & sync_rise);
    wire pos_change = align_evt & (lmfc_ff != 5'h00);
    wire [5:0] k_frames = {1'b0, frames_per_mf_m1} + 6'h01;

    function automatic logic [14:0] prbs_step8(input logic [14:0] s);
        logic [14:0] t;
        t = s;
        for (int i = 0; i < 8; i++)
            t = {t[13:0], t[14] ^ t[13]};
        return t;
    endfunction : prbs_step8

    function automatic logic [7:0] rpat_byte(input logic [3:0] i);
        logic [7:0] b;
        b = 8'hbe;
        unique case (i)
            4'h0: b = 8'hbe;
            4'h1: b = 8'hd7;
            4'h2: b = 8'h23;
            4'h3: b = 8'h47;
            4'h4: b = 8'h6b;
            4'h5: b = 8'h8f;
            4'h6: b = 8'hb3;
            4'h7: b = 8'h14;
            4'h8: b = 8'h5e;
            4'h9: b = 8'hfb;
            4'ha: b = 8'h35;
            4'hb: b = 8'h59;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : rpat_byte

    wire [14:0] nxt_prbs = prbs_step8(prbs_ff);
    wire [7:0] las_octet = (lmfc_ff == 5'h00) ? `SLSP_K28_0 :
                           (lmfc_ff == frames_per_mf_m1) ? `SLSP_K28_3 : {3'h0, lmfc_ff};
    wire las_k = (lmfc_ff == 5'h00) | (lmfc_ff == frames_per_mf_m1);
    slsp_pkg::slsp_char_t pat_char;
    slsp_pkg::slsp_char_t nxt_lane;

    always_comb
    begin
        pat_char = '{is_k: 1'b0, octet: adc_octet};
        unique case (slsp_pkg::slsp_pat_t'(pat_ff))
            slsp_pkg::SLSP_PAT_NORMAL: pat_char = '{is_k: 1'b0, octet: adc_octet};
            slsp_pkg::SLSP_PAT_K285: pat_char = '{is_k: 1'b1, octet: `SLSP_K28_5};
            slsp_pkg::SLSP_PAT_K287: pat_char = '{is_k: 1'b1, octet: `SLSP_K28_7};
            slsp_pkg::SLSP_PAT_D215: pat_char = '{is_k: 1'b0, octet: `SLSP_D21_5};
            slsp_pkg::SLSP_PAT_PRBS15: pat_char = '{is_k: 1'b0, octet: nxt_prbs[7:0]};
            slsp_pkg::SLSP_PAT_LANE_ALIGN: pat_char = '{is_k: las_k, octet: las_octet};
            slsp_pkg::SLSP_PAT_TEST_SAMPLES: pat_char = '{is_k: 1'b0, octet: ramp_ff};
            slsp_pkg::SLSP_PAT_RPAT: pat_char = '{is_k: 1'b0, octet: rpat_byte(rpat_idx_ff)};
        endcase
    end

    // the resync burst overrides any pattern so the receiver can realign
    assign nxt_lane = (comma_ff != 6'h00) ? '{is_k: 1'b1, octet: `SLSP_K28_5} : pat_char;

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            sysref_d_ff <= 1'b0;
            // sync request idles high, so a low reset value would fake a rising edge
            sync_d_ff <= 1'b1;
            lmfc_ff <= 5'h00;
            armed_ff <= 1'b0;
            idle_mf_ff <= 3'h0;
            comma_ff <= 6'h00;
            mf_idx_ff <= 2'h0;
            ramp_ff <= 8'h00;
            rpat_idx_ff <= 4'h0;
            prbs_ff <= `SLSP_PRBS_SEED;
            lane_ff <= '0;
        end
        else
        begin
            sysref_d_ff <= sysref;
            sync_d_ff <= sync_n;
            if (align_evt)
                lmfc_ff <= 5'h00;
            else if (mf_end)
                lmfc_ff <= 5'h00;
            else if (frame_tick)
                lmfc_ff <= lmfc_ff + 5'h01;
            // a pulse in the same cycle as a boundary keeps the logic armed
            if (!(sc1 && subcl_ff.alert))
            begin
                armed_ff <= 1'b0;
                idle_mf_ff <= 3'h0;
            end
            else if (sysref_rise)
            begin
                armed_ff <= 1'b1;
                idle_mf_ff <= 3'h0;
            end
            else if (armed_ff && mf_end)
            begin
                if (idle_mf_ff == subcl_ff.dearm_len)
                    armed_ff <= 1'b0;
                idle_mf_ff <= idle_mf_ff + 3'h1;
            end
            if (pos_change && subcl_ff.tx_sync)
                comma_ff <= k_frames;
            else if (frame_tick && comma_ff != 6'h00)
                comma_ff <= comma_ff - 6'h01;
            if (frame_tick)
            begin
                lane_ff <= nxt_lane;
                prbs_ff <= nxt_prbs;
                ramp_ff <= ramp_ff + 8'h01;
                rpat_idx_ff <= (rpat_idx_ff == `SLSP_RPAT_LAST) ? 4'h0 : rpat_idx_ff + 4'h1;
                if (mf_end)
                    mf_idx_ff <= mf_idx_ff + 2'h1;
            end
        end
    end

    assign lane_char = lane_ff;
    assign comma_burst = comma_ff != 6'h00;
    assign lmfc_wrap = (lmfc_ff == frames_per_mf_m1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    sequence s_pos_move;
        pos_change && subcl_ff.tx_sync;
    endsequence
    sequence s_burst_loaded;
        comma_ff == $past(k_frames);
    endsequence

    burst_len_a: assert property (s_pos_move |=> s_burst_loaded)
        else $error("resync burst length is not K frames");
    burst_char_a: assert property (frame_tick && comma_ff != 6'h00 |=>
        lane_ff.is_k && lane_ff.octet == `SLSP_K28_5)
        else $error("burst frame is not K28.5");
    alert_first_a: assert property (sc1 && subcl_ff.alert && !armed_ff && sysref_rise
        |-> !align_evt ##1 armed_ff)
        else $error("first pulse in alert mode did not only arm");
    dearm_len_a: assert property (armed_ff && mf_end && !sysref_rise && sc1
        && subcl_ff.alert && idle_mf_ff == subcl_ff.dearm_len && !wr_subcl |=> !armed_ff)
        else $error("logic not disarmed after R multiframes");
    sync_align_a: assert property (sc2 && sync_rise |=> lmfc_ff == 5'h00)
        else $error("sync rising edge did not realign multiframe");
    sc0_static_a: assert property (subcl_ff.subclass == `SLSP_SUBCL_0 |-> !align_evt)
        else $error("alignment event in subclass 0");
    k287_pat_a: assert property (pat_ff == 3'h2 && comma_ff == 6'h00 && frame_tick
        |=> lane_ff.is_k && lane_ff.octet == `SLSP_K28_7)
        else $error("K28.7 pattern not sent");
    // each new bit is the xor of the bits 14 and 15 places back in the stream
    prbs_out_a: assert property (pat_ff == 3'h4 && comma_ff == 6'h00 && frame_tick
        |=> lane_ff.octet == ($past(prbs_ff[14:7]) ^ $past(prbs_ff[13:6]))
        && !lane_ff.is_k)
        else $error("PRBS15 octet mismatch");
    mf_len_a: assert property (frame_tick && lmfc_ff == frames_per_mf_m1 && !align_evt
        |=> lmfc_ff == 5'h00)
        else $error("multiframe length is not K frames");
    drive_wr_a: assert property (wr_drv |=> lane_drive_current == $past(wr_data[1:0]))
        else $error("drive current not updated");
    unused_rd_a: assert property (acc_addr == `SLSP_ADDR_DRIVE |-> rd_data[7:2] == 6'h00)
        else $error("unused drive bits read nonzero");
endmodule : slsp_top
